// [rtl/mts_pkg.sv]
package mts_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] MTS_OFS_CMD = 8'h00;
    localparam logic [7:0] MTS_OFS_CFG = 8'h04;
    localparam logic [7:0] MTS_OFS_SAMP = 8'h08;
    localparam logic [7:0] MTS_OFS_TCNT = 8'h0C;
    localparam logic [7:0] MTS_OFS_DLY = 8'h10;
    localparam logic [7:0] MTS_OFS_STAT = 8'h14;
    localparam logic [7:0] MTS_OFS_RDGS = 8'h18;

    // ------------------------------------------------------------
    // command register bits (write one to act, read as zero)
    // ------------------------------------------------------------
    localparam int MTS_CMD_ARM = 0;
    localparam int MTS_CMD_ARM_RET = 1;
    localparam int MTS_CMD_CAF = 2;
    localparam int MTS_CMD_SETUP = 3;
    localparam int MTS_CMD_SWTRG = 4;
    localparam int MTS_CMD_GET = 5;
    localparam int MTS_CMD_DCL = 6;
    localparam int MTS_CMD_IFRST = 7;

    // ------------------------------------------------------------
    // configuration register fields
    // ------------------------------------------------------------
    localparam int MTS_CFG_SRC_LSB = 0;
    localparam int MTS_CFG_AUTO = 2;
    localparam int MTS_CFG_LOCAL = 3;
    localparam int MTS_CFG_FUNC_LSB = 4;
    localparam int MTS_CFG_RANGE_LSB = 6;
    localparam int MTS_CFG_ILC = 9;
    localparam int MTS_TCNT_UNB = 16;
    localparam int MTS_STAT_REJ = 2;
    localparam int MTS_STAT_PEND = 3;

    typedef enum logic [1:0] {MTS_SRC_IMM = 2'h0, MTS_SRC_BUS = 2'h1, MTS_SRC_EXT = 2'h2} mts_src_e;
    typedef enum logic [1:0] {MTS_FN_DCV = 2'h0, MTS_FN_RES = 2'h1, MTS_FN_TEMP = 2'h2} mts_func_e;
    // gray codes along idle -> wait -> delay -> measure
    typedef enum logic [1:0] {MTS_IDLE = 2'b00, MTS_WAIT = 2'b01, MTS_DELAY = 2'b11, MTS_MEAS = 2'b10} mts_st_e;

    // ------------------------------------------------------------
    // counts, limits and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] MTS_CNT_MIN = 16'h0001;
    localparam logic [15:0] MTS_CNT_MAX = 16'hC350;
    localparam logic [21:0] MTS_DLY_MAX_MS = 22'h36EE80;
    localparam logic [2:0] MTS_RNG_LOW = 3'h0;
    localparam logic [2:0] MTS_RNG_100K = 3'h5;
    localparam logic [2:0] MTS_RNG_1M = 3'h6;

    // delay counted in 100 us units
    localparam int MTS_CLK_HZ = 40000000;
    localparam int MTS_UNIT_US = 100;
    localparam int MTS_UNIT_CYC = MTS_CLK_HZ / 1000000 * MTS_UNIT_US;
    localparam logic [25:0] MTS_UNITS_PER_MS = 26'h000000A;
    localparam logic [25:0] MTS_AD_15MS = 26'h0000096;
    localparam logic [25:0] MTS_AD_1MS0 = 26'h000000A;
    localparam logic [25:0] MTS_AD_1MS5 = 26'h000000F;
    localparam logic [25:0] MTS_AD_4MS = 26'h0000028;
    localparam logic [25:0] MTS_AD_6MS = 26'h000003C;
    localparam logic [25:0] MTS_AD_40MS = 26'h0000190;
    localparam logic [25:0] MTS_AD_60MS = 26'h0000258;

    typedef struct packed {
        mts_st_e st;
        mts_src_e src;
        logic dly_auto;
        logic local_mode;
        mts_func_e func;
        logic [2:0] range;
        logic ilc_ge1;
        logic [15:0] samp_cnt;
        logic [15:0] trig_cnt;
        logic trig_unb;
        logic [21:0] dly_ms;
        logic [15:0] trig_done;
        logic [15:0] samp_done;
        logic [25:0] dly_left;
        logic [11:0] tick;
        logic ext_pend;
        logic ext_prev;
        logic rejected;
        logic [31:0] rdgs;
        logic meas_start;
        logic [31:0] prdata;
    } mts_state_s;

endpackage

// [rtl/mts_trigger_seq.sv]
// Operation
// - immediate source starts measuring once armed
// - software trigger accepted only while waiting
// - group execute trigger also triggers while waiting
// - bus triggers outside waiting ignored; accepted starts sequence
// - arm, arm-return, configure-arm-fetch all arm
// - local mode stays armed unless measuring
// - device clear aborts to idle
// - device clear keeps trigger settings
// - unbounded count runs until device clear
// - readings per trigger 1 to 50000
// - reading count resets to one
// - idle after programmed trigger count serviced
// - trigger count 1 to 50000 or unbounded
// - local mode acts as count one
// - trigger count resets to one
// - delay before every reading of burst
// - manual delay 0 to 3600 s, default auto
// - delay reverts to automatic
// - manual delay ignores function and range
// - dc voltage automatic delays
// - resistance automatic delays
// - temperature automatic delays
// - external low pulse is one trigger
// - one external trigger latched during reading
// - interface reset selects immediate source
`timescale 1ns/1ps
module mts_trigger_seq
    import mts_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_trig_n,
    input wire logic get_msg,
    input wire logic meas_done,
    output logic meas_start,
    output logic meas_busy,
    output logic trig_waiting
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] mts_clamp(input logic [31:0] v);
        if (v < {16'h0000, MTS_CNT_MIN})
        begin
            return MTS_CNT_MIN;
        end
        else if (v > {16'h0000, MTS_CNT_MAX})
        begin
            return MTS_CNT_MAX;
        end
        return v[15:0];
    endfunction

    function automatic logic [25:0] mts_auto_delay(input mts_func_e f, input logic [2:0] r, input logic slow);
        if (f == MTS_FN_DCV && r == MTS_RNG_LOW)
        begin
            return MTS_AD_15MS;
        end
        else if (f == MTS_FN_RES && r == MTS_RNG_100K)
        begin
            return slow ? MTS_AD_6MS : MTS_AD_4MS;
        end
        else if (f == MTS_FN_RES && r >= MTS_RNG_1M)
        begin
            return slow ? MTS_AD_60MS : MTS_AD_40MS;
        end
        // remaining dc, resistance and every temperature sensor
        return slow ? MTS_AD_1MS5 : MTS_AD_1MS0;
    endfunction

    function automatic logic [25:0] mts_delay_units(input mts_state_s s);
        logic [25:0] ms;
        ms = {4'h0, s.dly_ms};
        if (s.dly_auto)
        begin
            return mts_auto_delay(s.func, s.range, s.ilc_ge1);
        end
        return 26'(ms * MTS_UNITS_PER_MS);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    mts_state_s cur_r;
    mts_state_s cur_nxt;

    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic [7:0] cmd;
    logic ext_edge;
    logic trig_hit;
    logic last_trig;
    logic [15:0] eff_tcnt;
    logic [11:0] unit_last;

    assign unit_last = 12'(MTS_UNIT_CYC - 1);

    always_comb
    begin
        addr_ok = 1'b0;
        if (paddr == MTS_OFS_CMD)
        begin
            addr_ok = 1'b1;
        end
        else if (paddr == MTS_OFS_CFG)
        begin
            addr_ok = 1'b1;
        end
        else if (paddr == MTS_OFS_SAMP || paddr == MTS_OFS_TCNT)
        begin
            addr_ok = 1'b1;
        end
        else if (paddr == MTS_OFS_DLY || paddr == MTS_OFS_STAT || paddr == MTS_OFS_RDGS)
        begin
            addr_ok = 1'b1;
        end
    end

    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_setup = psel && !penable && !pwrite;
    assign cmd = (wr_en && paddr == MTS_OFS_CMD) ? pwdata[7:0] : 8'h00;
    // low-true pulse: count its leading edge once
    assign ext_edge = cur_r.ext_prev && !ext_trig_n;
    assign eff_tcnt = cur_r.local_mode ? MTS_CNT_MIN : cur_r.trig_cnt;

    always_comb
    begin
        cur_nxt = cur_r;
        cur_nxt.meas_start = 1'b0;
        cur_nxt.ext_prev = ext_trig_n;
        trig_hit = 1'b0;
        last_trig = 1'b0;

        // ------------------------------------------------------------
        // configuration writes
        // ------------------------------------------------------------
        if (wr_en && paddr == MTS_OFS_CFG)
        begin
            cur_nxt.src = (pwdata[MTS_CFG_SRC_LSB +: 2] == 2'h3) ? MTS_SRC_EXT
                : mts_src_e'(pwdata[MTS_CFG_SRC_LSB +: 2]);
            cur_nxt.dly_auto = pwdata[MTS_CFG_AUTO];
            cur_nxt.local_mode = pwdata[MTS_CFG_LOCAL];
            cur_nxt.func = (pwdata[MTS_CFG_FUNC_LSB +: 2] == 2'h3) ? MTS_FN_TEMP
                : mts_func_e'(pwdata[MTS_CFG_FUNC_LSB +: 2]);
            cur_nxt.range = pwdata[MTS_CFG_RANGE_LSB +: 3];
            cur_nxt.ilc_ge1 = pwdata[MTS_CFG_ILC];
        end
        if (wr_en && paddr == MTS_OFS_SAMP)
        begin
            cur_nxt.samp_cnt = mts_clamp(pwdata);
        end
        if (wr_en && paddr == MTS_OFS_TCNT)
        begin
            cur_nxt.trig_cnt = mts_clamp({16'h0000, pwdata[15:0]});
            cur_nxt.trig_unb = pwdata[MTS_TCNT_UNB];
        end
        if (wr_en && paddr == MTS_OFS_DLY)
        begin
            cur_nxt.dly_ms = (pwdata > {10'h000, MTS_DLY_MAX_MS}) ? MTS_DLY_MAX_MS : pwdata[21:0];
            cur_nxt.dly_auto = 1'b0;
        end
        if (wr_en && paddr == MTS_OFS_STAT && pwdata[MTS_STAT_REJ])
        begin
            cur_nxt.rejected = 1'b0;
        end

        // setup and configure-arm-fetch restore the trigger defaults
        if (cmd[MTS_CMD_SETUP] || cmd[MTS_CMD_CAF] || cmd[MTS_CMD_IFRST])
        begin
            cur_nxt.samp_cnt = MTS_CNT_MIN;
            cur_nxt.trig_cnt = MTS_CNT_MIN;
            cur_nxt.trig_unb = 1'b0;
            cur_nxt.dly_auto = 1'b1;
            cur_nxt.src = MTS_SRC_IMM;
        end

        // ------------------------------------------------------------
        // trigger sequence
        // ------------------------------------------------------------
        case (cur_r.st)
            MTS_IDLE:
            begin
                if (cmd[MTS_CMD_ARM] || cmd[MTS_CMD_ARM_RET] || cmd[MTS_CMD_CAF] || cur_r.local_mode)
                begin
                    cur_nxt.st = MTS_WAIT;
                    cur_nxt.trig_done = 16'h0000;
                end
            end
            MTS_WAIT:
            begin
                case (cur_r.src)
                    MTS_SRC_IMM: trig_hit = 1'b1;
                    MTS_SRC_BUS: trig_hit = cmd[MTS_CMD_SWTRG] || cmd[MTS_CMD_GET] || get_msg;
                    default: trig_hit = ext_edge || cur_r.ext_pend;
                endcase
                if (trig_hit)
                begin
                    cur_nxt.st = MTS_DELAY;
                    cur_nxt.ext_pend = 1'b0;
                    cur_nxt.trig_done = 16'(cur_r.trig_done + 16'h0001);
                    cur_nxt.samp_done = 16'h0000;
                    cur_nxt.dly_left = mts_delay_units(cur_nxt);
                    cur_nxt.tick = 12'h000;
                end
            end
            MTS_DELAY:
            begin
                if (cur_r.dly_left == 26'h0000000)
                begin
                    cur_nxt.st = MTS_MEAS;
                    cur_nxt.meas_start = 1'b1;
                end
                else if (cur_r.tick == unit_last)
                begin
                    cur_nxt.tick = 12'h000;
                    cur_nxt.dly_left = 26'(cur_r.dly_left - 26'h0000001);
                end
                else
                begin
                    cur_nxt.tick = 12'(cur_r.tick + 12'h001);
                end
            end
            default:
            begin
                if (meas_done)
                begin
                    cur_nxt.rdgs = 32'(cur_r.rdgs + 32'h00000001);
                    cur_nxt.samp_done = 16'(cur_r.samp_done + 16'h0001);
                    if (16'(cur_r.samp_done + 16'h0001) < cur_r.samp_cnt)
                    begin
                        cur_nxt.st = MTS_DELAY;
                        cur_nxt.dly_left = mts_delay_units(cur_nxt);
                        cur_nxt.tick = 12'h000;
                    end
                    else
                    begin
                        last_trig = !cur_r.trig_unb && !(cur_r.trig_done < eff_tcnt);
                        // local mode is permanently armed, so idle only briefly
                        cur_nxt.st = last_trig ? MTS_IDLE : MTS_WAIT;
                    end
                end
            end
        endcase

        // an external edge outside waiting is held once, never while idle
        if (cur_r.src == MTS_SRC_EXT && ext_edge && cur_r.st != MTS_WAIT && cur_r.st != MTS_IDLE)
        begin
            cur_nxt.ext_pend = 1'b1;
        end

        // software trigger refused outside waiting; set beats clear
        if (cmd[MTS_CMD_SWTRG] && !(cur_r.st == MTS_WAIT && cur_r.src == MTS_SRC_BUS))
        begin
            cur_nxt.rejected = 1'b1;
        end

        // device clear aborts without touching settings; interface reset also restores the defaults
        if (cmd[MTS_CMD_DCL] || cmd[MTS_CMD_IFRST])
        begin
            cur_nxt.st = MTS_IDLE;
            cur_nxt.ext_pend = 1'b0;
            cur_nxt.meas_start = 1'b0;
            cur_nxt.trig_done = 16'h0000;
            cur_nxt.samp_done = 16'h0000;
            cur_nxt.dly_left = 26'h0000000;
        end

        // ------------------------------------------------------------
        // read data captured in the setup phase
        // ------------------------------------------------------------
        if (rd_setup)
        begin
            if (paddr == MTS_OFS_CFG)
            begin
                cur_nxt.prdata = {22'h000000, cur_r.ilc_ge1, cur_r.range, cur_r.func,
                    cur_r.local_mode, cur_r.dly_auto, cur_r.src};
            end
            else if (paddr == MTS_OFS_SAMP)
            begin
                cur_nxt.prdata = {16'h0000, cur_r.samp_cnt};
            end
            else if (paddr == MTS_OFS_TCNT)
            begin
                cur_nxt.prdata = {15'h0000, cur_r.trig_unb, cur_r.trig_cnt};
            end
            else if (paddr == MTS_OFS_DLY)
            begin
                cur_nxt.prdata = {10'h000, cur_r.dly_ms};
            end
            else if (paddr == MTS_OFS_STAT)
            begin
                cur_nxt.prdata = {cur_r.trig_done, 12'h000, cur_r.ext_pend, cur_r.rejected, cur_r.st};
            end
            else if (paddr == MTS_OFS_RDGS)
            begin
                cur_nxt.prdata = cur_r.rdgs;
            end
            else
            begin
                cur_nxt.prdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur_r <= '{st: MTS_IDLE, src: MTS_SRC_IMM, dly_auto: 1'b1, func: MTS_FN_DCV,
                samp_cnt: MTS_CNT_MIN, trig_cnt: MTS_CNT_MIN, ext_prev: 1'b1, default: '0};
        end
        else
        begin
            cur_r <= cur_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata = cur_r.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign meas_start = cur_r.meas_start;
    assign meas_busy = (cur_r.st == MTS_DELAY) || (cur_r.st == MTS_MEAS);
    assign trig_waiting = (cur_r.st == MTS_WAIT);

endmodule

// [dv/mts_trigger_seq_asserts.sv]
`timescale 1ns/1ps
module mts_trigger_seq_asserts
    import mts_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ext_trig_n,
    input wire logic get_msg,
    input wire logic meas_done,
    input wire logic meas_start,
    input wire logic meas_busy,
    input wire logic trig_waiting
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic cmd_wr;
    assign cmd_wr = psel && penable && pwrite && paddr == MTS_OFS_CMD;
    // --------------------------------
    // command steps
    // --------------------------------
    sequence s_arm_from_idle;
        !meas_busy && !trig_waiting && cmd_wr && pwdata[7:0] == 8'h01;
    endsequence
    sequence s_dev_clear;
        cmd_wr && pwdata[7:0] == 8'h40;
    endsequence
    sequence s_idle;
        !meas_busy && !trig_waiting;
    endsequence
    property p_arm;
        s_arm_from_idle |=> trig_waiting;
    endproperty
    a_arm: assert property (p_arm) else $error("arm did not reach waiting");
    property p_clear;
        s_dev_clear |=> s_idle;
    endproperty
    a_clear: assert property (p_clear) else $error("device clear did not reach idle");
    property p_enter_busy;
        $rose(meas_busy) |-> $past(trig_waiting);
    endproperty
    a_enter_busy: assert property (p_enter_busy) else $error("sequence started outside waiting");
    property p_leave_busy;
        $fell(meas_busy) |-> $past(meas_done) || $past(cmd_wr);
    endproperty
    a_leave_busy: assert property (p_leave_busy) else $error("busy dropped without reading done");
    property p_start_pulse;
        meas_start |=> !meas_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("reading start longer than one cycle");
    property p_start_busy;
        meas_start |-> meas_busy && !trig_waiting;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("reading start outside sequence");
    property p_excl;
        !(meas_busy && trig_waiting);
    endproperty
    a_excl: assert property (p_excl) else $error("busy and waiting together");
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready in access phase");
    property p_unmapped;
        psel && penable && paddr > MTS_OFS_RDGS |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_err_access;
        pslverr |-> psel && penable;
    endproperty
    a_err_access: assert property (p_err_access) else $error("error outside access phase");
endmodule
bind mts_trigger_seq mts_trigger_seq_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_trig_n(ext_trig_n), .get_msg(get_msg), .meas_done(meas_done), .meas_start(meas_start),
    .meas_busy(meas_busy), .trig_waiting(trig_waiting));

// [dv/mts_meas_partner.sv]
`timescale 1ns/1ps
module mts_meas_partner
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic meas_start,
    input wire logic [3:0] lat,
    input wire logic ext_fire,
    output logic meas_done,
    output logic ext_trig_n
);
    logic [4:0] busy_left;
    logic [1:0] low_left;
    // pulled-up trigger line, low only while a pulse is sent
    assign ext_trig_n = (low_left == 2'h0);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_left <= 5'h00;
            low_left <= 2'h0;
            meas_done <= 1'b0;
        end
        else
        begin
            meas_done <= 1'b0;
            if (meas_start)
                busy_left <= {1'b0, lat} + 5'h01;
            else if (busy_left != 5'h00)
            begin
                busy_left <= busy_left - 5'h01;
                meas_done <= (busy_left == 5'h01);
            end
            if (ext_fire)
                low_left <= 2'h3;
            else if (low_left != 2'h0)
                low_left <= low_left - 2'h1;
        end
    end
endmodule

// [dv/mts_trigger_seq_tb.sv]
`timescale 1ns/1ps
module mts_trigger_seq_tb
    import mts_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, ext_trig_n, get_msg, meas_done;
    logic meas_start, meas_busy, trig_waiting, ext_fire, err_v;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_v, r0;
    logic [3:0] lat;
    int bad_count = 0, n_compared = 0, n_starts = 0, cyc = 0, seed = 32'h6b8e635b, s0, t0, i;
    logic [7:0] ca[4] = '{MTS_OFS_SAMP, MTS_OFS_SAMP, MTS_OFS_TCNT, MTS_OFS_DLY};
    logic [31:0] cw[4] = '{32'h0, 32'h0000FFFF, 32'h0, 32'hFFFFFFFF};
    logic [31:0] ce[4] = '{32'h1, 32'h0000C350, 32'h1, 32'h0036EE80};
    mts_trigger_seq DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_trig_n(ext_trig_n), .get_msg(get_msg), .meas_done(meas_done), .meas_start(meas_start),
        .meas_busy(meas_busy), .trig_waiting(trig_waiting));
    mts_meas_partner u_partner (.pclk(pclk), .presetn(presetn), .meas_start(meas_start), .lat(lat),
        .ext_fire(ext_fire), .meas_done(meas_done), .ext_trig_n(ext_trig_n));
    always #12.5 pclk = ~pclk;
    // --------------------------------
    // shared tasks
    // --------------------------------
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_n(input int target);
        int k;
        k = 0;
        while (n_starts < target && k < 50000)
        begin
            @(negedge pclk);
            k++;
        end
    endtask
    task wait_idle;
        int k;
        k = 0;
        do
        begin
            @(negedge pclk);
            k++;
        end
        while ((meas_busy !== 1'b0 || trig_waiting !== 1'b0) && k < 2000);
        check("idle", {30'h0, meas_busy, trig_waiting}, 32'h0);
    endtask
    task fire;
        @(posedge pclk);
        ext_fire <= 1'b1;
        @(posedge pclk);
        ext_fire <= 1'b0;
    endtask
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (meas_start === 1'b1)
            n_starts <= n_starts + 1;
        if (cyc == 90000)
        begin
            bad_count++;
            give_verdict;
        end
    end
    initial
    begin
        {presetn, psel, penable, pwrite, ext_fire, get_msg} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        lat = 4'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, MTS_OFS_CFG, 32'h0);
        check("cfg_rst", rd_v, 32'h00000004);
        apb(1'b0, MTS_OFS_SAMP, 32'h0);
        check("samp_rst", rd_v, 32'h1);
        apb(1'b0, MTS_OFS_TCNT, 32'h0);
        check("tcnt_rst", rd_v, 32'h1);
        apb(1'b0, 8'h1C, 32'h0);
        for (i = 0; i < 4; i++)
        begin
            apb(1'b1, ca[i], cw[i]);
            apb(1'b0, ca[i], 32'h0);
            check("clamp", rd_v, ce[i]);
        end
        r0 = 32'h1 + ($unsigned($random(seed)) % 50000);
        apb(1'b1, MTS_OFS_SAMP, r0);
        apb(1'b0, MTS_OFS_SAMP, 32'h0);
        check("samp_rand", rd_v, r0);
        apb(1'b1, MTS_OFS_DLY, 32'h0);
        apb(1'b1, MTS_OFS_SAMP, 32'h3);
        apb(1'b1, MTS_OFS_TCNT, 32'h2);
        lat <= 4'($random(seed));
        apb(1'b0, MTS_OFS_RDGS, 32'h0);
        r0 = rd_v;
        s0 = n_starts;
        apb(1'b1, MTS_OFS_CMD, 32'h1);
        wait_idle;
        check("burst", 32'(n_starts - s0), 32'h6);
        apb(1'b0, MTS_OFS_RDGS, 32'h0);
        check("rdgs", rd_v - r0, 32'h6);
        apb(1'b1, MTS_OFS_SAMP, 32'h1);
        apb(1'b1, MTS_OFS_TCNT, 32'h1);
        apb(1'b1, MTS_OFS_CFG, 32'h1);
        apb(1'b1, MTS_OFS_CMD, 32'h10);
        apb(1'b0, MTS_OFS_STAT, 32'h0);
        check("rejected", {31'h0, rd_v[MTS_STAT_REJ]}, 32'h1);
        apb(1'b1, MTS_OFS_STAT, 32'h4);
        for (i = 0; i < 3; i++)
        begin
            s0 = n_starts;
            apb(1'b1, MTS_OFS_CMD, 32'h1);
            repeat (4) @(negedge pclk);
            check("bus_hold", {30'h0, meas_busy, trig_waiting}, 32'h1);
            if (i == 2)
                fire_get();
            else
                apb(1'b1, MTS_OFS_CMD, 32'h10 << i);
            wait_idle;
            check("bus_trig", 32'(n_starts - s0), 32'h1);
        end
        apb(1'b1, MTS_OFS_CFG, 32'h2);
        apb(1'b1, MTS_OFS_TCNT, 32'h2);
        lat <= 4'hF;
        s0 = n_starts;
        apb(1'b1, MTS_OFS_CMD, 32'h1);
        fire();
        wait_n(s0 + 1);
        fire();
        wait_idle;
        check("ext_latched", 32'(n_starts - s0), 32'h2);
        apb(1'b1, MTS_OFS_CFG, 32'h0);
        apb(1'b1, MTS_OFS_SAMP, 32'h2);
        apb(1'b1, MTS_OFS_TCNT, 32'h10003);
        s0 = n_starts;
        apb(1'b1, MTS_OFS_CMD, 32'h1);
        wait_n(s0 + 10);
        check("unb_run", 32'(n_starts >= s0 + 10), 32'h1);
        apb(1'b1, MTS_OFS_CMD, 32'h40);
        @(negedge pclk);
        check("dcl_idle", {30'h0, meas_busy, trig_waiting}, 32'h0);
        apb(1'b0, MTS_OFS_TCNT, 32'h0);
        check("dcl_tcnt", rd_v, 32'h10003);
        apb(1'b0, MTS_OFS_SAMP, 32'h0);
        check("dcl_samp", rd_v, 32'h2);
        apb(1'b1, MTS_OFS_CMD, 32'h8);
        apb(1'b0, MTS_OFS_TCNT, 32'h0);
        check("setup_tcnt", rd_v, 32'h1);
        apb(1'b0, MTS_OFS_CFG, 32'h0);
        check("setup_cfg", rd_v, 32'h4);
        // dc voltage, second range, short integration: 1.0 ms automatic
        apb(1'b1, MTS_OFS_CFG, 32'h44);
        s0 = n_starts;
        t0 = cyc;
        apb(1'b1, MTS_OFS_CMD, 32'h1);
        wait_n(s0 + 1);
        t0 = cyc - t0 - int'(MTS_AD_1MS0) * MTS_UNIT_CYC;
        check("auto_dly", 32'(t0 >= 0 && t0 <= 12), 32'h1);
        wait_idle;
        apb(1'b1, MTS_OFS_TCNT, 32'h3);
        apb(1'b1, MTS_OFS_CFG, 32'h8);
        s0 = n_starts;
        wait_n(s0 + 3);
        check("local_arm", 32'(n_starts >= s0 + 3), 32'h1);
        apb(1'b0, MTS_OFS_STAT, 32'h0);
        check("local_cnt", 32'(rd_v[31:16] <= 16'h0001), 32'h1);
        apb(1'b1, MTS_OFS_CFG, 32'h0);
        apb(1'b1, MTS_OFS_CMD, 32'h40);
        wait_idle;
        apb(1'b0, MTS_OFS_TCNT, 32'h0);
        check("remote_tcnt", rd_v, 32'h3);
        give_verdict;
    end
    task fire_get;
        @(posedge pclk);
        get_msg <= 1'b1;
        @(posedge pclk);
        get_msg <= 1'b0;
    endtask
endmodule
